//--- verilog/sts_consts.vh
/*
 constants for the supply tracking sequencer: timing figures and counts.
 assumes a 200 MHz system clock and comparator flags from the analog side.
*/
// Summary of operation
// - idle until lockout clears; always watch lockout
// - qualify: breaker clear, all monitors in range
// - timer must be discharged before each delay
// - ramp gate, wait gate-full, keep checking it
// - enable sense switches, wait switch-full flag
// - sense switch gate ramps at controlled rate
// - second timer delay before final state
// - final state releases power good, keeps monitoring
// - any interruption drops gate, power good, switches
// - lockout on undervoltage; resume at qualify
// - priority: lockout over fault over error
// - breaker latches after over-current beyond 1us
// - first monitor low 150us clears breaker latch
// - lockout beyond 10us clears breaker latch
// - any monitor out of range raises error
// - loss of gate-full after full is error
// - sense switches only while load switches on
// - threshold trip starts gate and discharges timer
// - timer discharged except delays and lockout
`ifndef STS_CONSTS_VH
`define STS_CONSTS_VH
`define STS_CLK_MHZ 200
`define STS_TRIP_NS 1000
`define STS_BRK_RST_US 150
`define STS_UVLO_RST_US 10
// longer than the figure: strictly more than the time is required
`define STS_TRIP_CYC (((`STS_TRIP_NS * `STS_CLK_MHZ) / 1000) + 1)
`define STS_BRK_RST_CYC ((`STS_BRK_RST_US * `STS_CLK_MHZ) + 1)
`define STS_UVLO_RST_CYC ((`STS_UVLO_RST_US * `STS_CLK_MHZ) + 1)
`define STS_NSYNC 8
`endif

//--- verilog/sts_sync.v
/*
 two-flop synchroniser bank for asynchronous comparator flags.
 assumes inputs change independently of clk_i.
*/
module sts_sync #(
  parameter W = 8
) (
  input wire clk_i,
  input wire rstn_i,
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_o
);
  reg [W-1:0] meta_r;

  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      meta_r <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end
    else
    begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule // sts_sync

//--- verilog/sts_sequencer.v
/*
 power-on sequencer for a multi-supply tracker: waits for supply lockout
 to clear, qualifies breaker and monitors, runs two timer delays around the
 gate ramp and sense switch enable, then releases power good.
 assumes analog comparators deliver the flags; the sense switch gate ramp
 rate itself is set by the analog current source behind sense_en_o.
*/
`include "sts_consts.vh"
module sts_sequencer #(
  parameter TRIP_CYC = `STS_TRIP_CYC,
  parameter BRK_RST_CYC = `STS_BRK_RST_CYC,
  parameter UVLO_RST_CYC = `STS_UVLO_RST_CYC
) (
  input wire clk_i,
  input wire rstn_i,
  input wire supply_ok_i,
  input wire [4:0] mon_low_ok_i,
  input wire [4:0] mon_ov_i,
  input wire overcurrent_i,
  input wire timer_low_i,
  input wire timer_trip_i,
  input wire gate_full_i,
  input wire switch_full_i,
  output reg gate_en_o,
  output reg sense_en_o,
  output reg power_good_out_o,
  output reg timer_ramp_o,
  output reg timer_dis_o,
  output reg breaker_latched_o,
  output reg lockout_o,
  output reg error_o
);
  localparam [7:0] S_WAIT = 8'h01;
  localparam [7:0] S_QUAL = 8'h02;
  localparam [7:0] S_DLY1 = 8'h04;
  localparam [7:0] S_GATE = 8'h08;
  localparam [7:0] S_SENSE = 8'h10;
  localparam [7:0] S_DLY2 = 8'h20;
  localparam [7:0] S_GOOD = 8'h40;
  localparam [7:0] S_LOCK = 8'h80;

  wire [`STS_NSYNC-1:0] raw_w;
  wire [`STS_NSYNC-1:0] syn_w;
  reg [4:0] mlow_r;
  wire sup_ok;
  wire oc;
  wire t_low;
  wire t_trip;
  wire g_full;
  wire s_full;
  wire mon_first_low;
  wire mons_ok;
  wire gate_lost;
  wire fault;
  wire err;
  wire lock;
  reg [7:0] st_r;
  reg [7:0] st_nxt;
  reg gate_seen_r;
  reg [15:0] oc_cnt_r;
  reg [15:0] rst_cnt_r;
  reg [15:0] uv_cnt_r;

  assign raw_w = {supply_ok_i, overcurrent_i, timer_low_i, timer_trip_i,
                  gate_full_i, switch_full_i, &mon_low_ok_i, |mon_ov_i};

  sts_sync #(
    .W(`STS_NSYNC)
  ) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .async_i(raw_w),
    .sync_o(syn_w)
  );

  // per-monitor flags kept for the first monitor reset detection
  reg [4:0] mlow_m_r;
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      mlow_m_r <= 5'h00;
      mlow_r <= 5'h00;
    end
    else
    begin
      mlow_m_r <= mon_low_ok_i;
      mlow_r <= mlow_m_r;
    end
  end

  assign sup_ok = syn_w[7];
  assign oc = syn_w[6];
  assign t_low = syn_w[5];
  assign t_trip = syn_w[4];
  assign g_full = syn_w[3];
  assign s_full = syn_w[2];
  // monitor 0 is the first monitor input, its low reading also resets
  assign mon_first_low = ~mlow_r[0];
  assign mons_ok = syn_w[1] & ~syn_w[0];
  assign gate_lost = gate_seen_r & ~g_full;
  assign lock = ~sup_ok;
  assign fault = breaker_latched_o;
  assign err = ~mons_ok | gate_lost;

  // breaker persistence: over-current must hold for TRIP_CYC cycles
  always @(posedge clk_i)
  begin
    if (!rstn_i)
      oc_cnt_r <= 16'h0000;
    else if (!oc)
      oc_cnt_r <= 16'h0000;
    else if (oc_cnt_r != TRIP_CYC[15:0])
      oc_cnt_r <= oc_cnt_r + 16'h0001;
  end

  // monitor reset count runs only after over-current has ended; lockout count ignores it
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      rst_cnt_r <= 16'h0000;
      uv_cnt_r <= 16'h0000;
    end
    else
    begin
      if (!mon_first_low || oc)
        rst_cnt_r <= 16'h0000;
      else if (rst_cnt_r != BRK_RST_CYC[15:0])
        rst_cnt_r <= rst_cnt_r + 16'h0001;
      if (!lock)
        uv_cnt_r <= 16'h0000;
      else if (uv_cnt_r != UVLO_RST_CYC[15:0])
        uv_cnt_r <= uv_cnt_r + 16'h0001;
    end
  end

  // set wins over clear so a fresh trip is never lost
  always @(posedge clk_i)
  begin
    if (!rstn_i)
      breaker_latched_o <= 1'b0;
    else if (oc_cnt_r == TRIP_CYC[15:0])
      breaker_latched_o <= 1'b1;
    else if (rst_cnt_r == BRK_RST_CYC[15:0])
      breaker_latched_o <= 1'b0;
    else if (uv_cnt_r == UVLO_RST_CYC[15:0])
      breaker_latched_o <= 1'b0;
  end

  always @*
  begin
    st_nxt = st_r;
    if (lock)
    begin
      // lockout overrides everything; initial wait stays initial
      if (st_r != S_WAIT)
        st_nxt = S_LOCK;
    end
    else if (fault)
      st_nxt = S_QUAL;
    else if (err && st_r != S_WAIT && st_r != S_LOCK)
      st_nxt = S_QUAL;
    else
    begin
      case (st_r)
        S_WAIT: st_nxt = S_QUAL;
        S_LOCK: st_nxt = S_QUAL;
        S_QUAL:
          if (!err && t_low)
            st_nxt = S_DLY1;
        S_DLY1:
          if (t_trip)
            st_nxt = S_GATE;
        S_GATE:
          if (g_full)
            st_nxt = S_SENSE;
        S_SENSE:
          if (s_full && t_low)
            st_nxt = S_DLY2;
        S_DLY2:
          if (t_trip)
            st_nxt = S_GOOD;
        S_GOOD: st_nxt = S_GOOD;
        default: st_nxt = S_WAIT;
      endcase
    end
  end

  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      st_r <= S_WAIT;
      gate_seen_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      if (st_nxt == S_WAIT || st_nxt == S_LOCK || st_nxt == S_QUAL ||
          st_nxt == S_DLY1 || st_nxt == S_GATE)
        gate_seen_r <= (st_r == S_GATE) & g_full & (st_nxt == S_SENSE);
      else if (st_r == S_GATE)
        gate_seen_r <= 1'b1;
    end
  end

  // outputs follow the next state so an interruption drops them at once
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      gate_en_o <= 1'b0;
      sense_en_o <= 1'b0;
      power_good_out_o <= 1'b0;
      timer_ramp_o <= 1'b0;
      timer_dis_o <= 1'b1;
      lockout_o <= 1'b0;
      error_o <= 1'b0;
    end
    else
    begin
      gate_en_o <= (st_nxt == S_GATE) | (st_nxt == S_SENSE) |
                   (st_nxt == S_DLY2) | (st_nxt == S_GOOD);
      // only in states where the gate is already driven
      sense_en_o <= (st_nxt == S_SENSE) | (st_nxt == S_DLY2) |
                    (st_nxt == S_GOOD);
      power_good_out_o <= (st_nxt == S_GOOD);
      timer_ramp_o <= (st_nxt == S_DLY1) | (st_nxt == S_DLY2);
      timer_dis_o <= ~((st_nxt == S_DLY1) | (st_nxt == S_DLY2) |
                       (st_nxt == S_LOCK) | lock);
      lockout_o <= lock;
      error_o <= err & ~lock & ~fault;
    end
  end
endmodule // sts_sequencer

//--- bench/sts_seq_properties.sv
/*
 checker for the supply tracking sequencer outputs.
 assumes one clock and the synchronous active-low reset.
*/
module sts_seq_properties (
  input wire clk_i,
  input wire rstn_i,
  input wire supply_ok_i,
  input wire [4:0] mon_low_ok_i,
  input wire overcurrent_i,
  input wire gate_en_o,
  input wire sense_en_o,
  input wire power_good_out_o,
  input wire timer_ramp_o,
  input wire timer_dis_o,
  input wire breaker_latched_o,
  input wire lockout_o,
  input wire error_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  property p_sense; sense_en_o |-> gate_en_o; endproperty
  a_sense: assert property (p_sense) else $error("sense without gate");
  property p_good;
    power_good_out_o |-> gate_en_o && sense_en_o;
  endproperty
  a_good: assert property (p_good) else $error("good early");
  property p_tmr; timer_ramp_o |-> !timer_dis_o; endproperty
  a_tmr: assert property (p_tmr) else $error("ramp into discharge");
  property p_lock; lockout_o |-> !error_o && !gate_en_o; endproperty
  a_lock: assert property (p_lock) else $error("lockout not ruling");
  property p_brk;
    breaker_latched_o [*3] |-> !gate_en_o && !power_good_out_o;
  endproperty
  a_brk: assert property (p_brk) else $error("fault kept gate");
  property p_trip;
    overcurrent_i [*8] |-> ##[0:4] breaker_latched_o;
  endproperty
  a_trip: assert property (p_trip) else $error("breaker missed");
  property p_uv; (!supply_ok_i) [*5] |-> !gate_en_o; endproperty
  a_uv: assert property (p_uv) else $error("gate in undervoltage");
  property p_start;
    $rose(gate_en_o) |-> timer_dis_o && !timer_ramp_o;
  endproperty
  a_start: assert property (p_start) else $error("timer not reset");
  property p_mon;
    (mon_low_ok_i != 5'h1f) [*6] |-> !power_good_out_o;
  endproperty
  a_mon: assert property (p_mon) else $error("good with bad monitor");
endmodule // sts_seq_properties

bind sts_sequencer sts_seq_properties i_sts_seq_properties (
  .clk_i(clk_i), .rstn_i(rstn_i), .supply_ok_i(supply_ok_i),
  .mon_low_ok_i(mon_low_ok_i), .overcurrent_i(overcurrent_i),
  .gate_en_o(gate_en_o), .sense_en_o(sense_en_o),
  .power_good_out_o(power_good_out_o), .timer_ramp_o(timer_ramp_o),
  .timer_dis_o(timer_dis_o), .breaker_latched_o(breaker_latched_o),
  .lockout_o(lockout_o), .error_o(error_o));

//--- bench/sts_far_model.sv
/*
 far side: timing capacitor, gate and sense switch gate charge.
 assumes enables from the sequencer; ramps are counted in clocks.
*/
module sts_far_model (
  input wire logic clk_i,
  input wire logic gate_en_i,
  input wire logic sense_en_i,
  input wire logic ramp_i,
  input wire logic dis_i,
  output logic low_o,
  output logic trip_o,
  output logic gate_full_o,
  output logic sw_full_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int t = 0;
  int g = 0;
  int s = 0;
  // discharge wins over ramp, as a pull-down outruns the source
  always @(posedge clk_i)
  begin
    t <= dis_i ? 0 : ramp_i ? t + 1 : t;
    g <= gate_en_i ? g + 1 : 0;
    s <= sense_en_i ? s + 1 : 0;
  end
  assign low_o = (t == 0);
  assign trip_o = (t >= 12);
  assign gate_full_o = (g >= 6);
  assign sw_full_o = (s >= 6);
endmodule // sts_far_model

//--- bench/tb_top.sv
/*
 testbench: start-up, error, breaker fault and lockout scenarios.
 assumes short counts 4, 20 and 10 cycles for the persistence timers.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 0, rstn_i = 0, supply_ok_i = 1, overcurrent_i = 0;
  logic [4:0] mon_low_ok_i = 5'h1f;
  logic [4:0] mon_ov_i = 5'h00;
  logic tl, tt, gf, sf, gate_en_o, sense_en_o, power_good_out_o;
  logic timer_ramp_o, timer_dis_o, breaker_latched_o, lockout_o, error_o;
  int error_cnt = 0, checks = 0;
  always #2.5 clk_i = ~clk_i;
  sts_sequencer #(.TRIP_CYC(4), .BRK_RST_CYC(20), .UVLO_RST_CYC(10))
    i_sts_sequencer (.clk_i(clk_i), .rstn_i(rstn_i),
    .supply_ok_i(supply_ok_i), .mon_low_ok_i(mon_low_ok_i),
    .mon_ov_i(mon_ov_i), .overcurrent_i(overcurrent_i), .timer_low_i(tl),
    .timer_trip_i(tt), .gate_full_i(gf), .switch_full_i(sf),
    .gate_en_o(gate_en_o), .sense_en_o(sense_en_o),
    .power_good_out_o(power_good_out_o), .timer_ramp_o(timer_ramp_o),
    .timer_dis_o(timer_dis_o), .breaker_latched_o(breaker_latched_o),
    .lockout_o(lockout_o), .error_o(error_o));
  sts_far_model i_sts_far_model (.clk_i(clk_i), .gate_en_i(gate_en_o),
    .sense_en_i(sense_en_o), .ramp_i(timer_ramp_o), .dis_i(timer_dis_o),
    .low_o(tl), .trip_o(tt), .gate_full_o(gf), .sw_full_o(sf));
  task automatic chk(input logic g, input logic e);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wt_good(input logic e);
    int n = 0;
    while (power_good_out_o !== e && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(power_good_out_o, e);
  endtask
  task automatic t_start;
    wt_good(1);
    chk(sense_en_o, 1);
    chk(timer_dis_o, 1);
    chk(timer_ramp_o, 0);
  endtask
  task automatic t_err;
    mon_low_ok_i <= 5'h1b;
    cyc(6);
    chk(error_o, 1);
    chk(gate_en_o, 0);
    mon_low_ok_i <= 5'h1f;
    wt_good(1);
    // overvoltage on one monitor must interrupt as well
    mon_ov_i <= 5'h04;
    cyc(6);
    chk(error_o, 1);
    chk(power_good_out_o, 0);
    chk(sense_en_o, 0);
    mon_ov_i <= 5'h00;
    wt_good(1);
  endtask
  task automatic t_fault;
    overcurrent_i <= 1;
    cyc(3);
    overcurrent_i <= 0;
    cyc(6);
    chk(breaker_latched_o, 0);
    overcurrent_i <= 1;
    cyc(10);
    chk(breaker_latched_o, 1);
    chk(power_good_out_o, 0);
    overcurrent_i <= 0;
    mon_low_ok_i <= 5'h1e;
    cyc(30);
    mon_low_ok_i <= 5'h1f;
    cyc(6);
    chk(breaker_latched_o, 0);
    wt_good(1);
  endtask
  task automatic t_lock;
    overcurrent_i <= 1;
    cyc(10);
    chk(breaker_latched_o, 1);
    overcurrent_i <= 0;
    supply_ok_i <= 0;
    mon_low_ok_i <= 5'h0f;
    cyc(20);
    chk(lockout_o, 1);
    chk(error_o, 0);
    supply_ok_i <= 1;
    mon_low_ok_i <= 5'h1f;
    cyc(6);
    chk(breaker_latched_o, 0);
    wt_good(1);
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    cyc(4);
    rstn_i <= 1;
    t_start();
    t_err();
    t_fault();
    t_lock();
    close_out();
  end
  // whole run needs well under 2000 cycles
  initial
  begin
    #25000;
    error_cnt++;
    close_out();
  end
endmodule // tb_top
